// File: pic_defines.vh
// constants for the printer interface control decode
`ifndef PIC_DEFINES_VH
`define PIC_DEFINES_VH
`define PIC_G0_PAPER_MOVE 3'h0
`define PIC_G0_ONLINE     3'h1
`define PIC_G3_STEPPER    4'h1
`define PIC_G3_LOAD_COL   4'h2
`define PIC_G3_CLAMP_OFF  4'h3
`define PIC_G3_CLAMP_ON   4'h4
`define PIC_G3_RAIL_ON    4'h5
`define PIC_G3_RAIL_OFF   4'h6
`define PIC_G3_FAULT_CLR  4'h7
`define PIC_G3_RIBBON_CLR 4'h8
`define PIC_G3_FMT_ADDR   4'h9
`define PIC_G3_PAPER_CLR  4'hA
`define PIC_G3_MCLR_SET   4'hB
`define PIC_G3_DISPLAY    4'hD
`define PIC_G3_BUFCLR_RST 4'hF
`define PIC_SRC_FORMS     3'h0
`define PIC_SRC_USER      3'h1
`define PIC_SRC_CFG2      3'h2
`define PIC_SRC_CFG_LOW   3'h3
`define PIC_SRC_CFG_HIGH  3'h4
`define PIC_SRC_INTERLOCK 3'h5
`define PIC_SRC_PANEL     3'h6
`define PIC_SHORT_MAX     6'h0F
`define PIC_LONG_MAX      6'h3F
`define PIC_COUNT_ZERO    6'h00
`define PIC_CODE_HI       13
`define PIC_CODE_LO       10
`define PIC_SEL_HI        12
`define PIC_VALUE_BIT     13
`define PIC_SRC_HI        11
`define PIC_SRC_LO        9
`define PIC_QUAL_LO       12
`define PIC_QUAL_HI       13
`define PIC_SRC_NONE      3'h7
`define PIC_SEL_IDLE      7'h7F
`define PIC_G3_IDLE       16'hFFFF
`define PIC_DATA_CTRL_ON  7
`define PIC_DATA_CTRL_OFF 5
`endif

// File: pic_latch8.v
// eight-bit addressable set/clear latch
`timescale 1ns/1ns
module pic_latch8
(
	input  wire       clk_in,
	input  wire       rst_in,
	input  wire       clear_in,
	input  wire       enable_n_in,
	input  wire [2:0] sel_in,
	input  wire       value_in,
	output reg  [7:0] q_out
);
	always @(posedge clk_in or posedge rst_in)
	begin
		if (rst_in)
			q_out <= 8'h00;
		else if (clear_in)
			q_out <= 8'h00;
		else if (!enable_n_in)
			q_out[sel_in] <= value_in;
	end
endmodule // pic_latch8

// File: pic_control_decode.v
// printer interface control decode: format options, source decoder, control groups 0 and 3
`timescale 1ns/1ns
`include "pic_defines.vh"
module pic_control_decode
#(
	parameter W = 8
)
(
	input  wire         clk_in,
	input  wire         rst_in,
	input  wire         group0_enable_n_in,
	input  wire         group0_clear_in,
	input  wire         group3_enable_n_in,
	input  wire         source_strobe_n_in,
	input  wire [15:0]  cpu_addr_line_in,
	input  wire [7:0]   user_data_in,
	input  wire         opt_ctrl_bit_sel_in,
	input  wire         opt_polarity_in,
	input  wire         opt_long_count_in,
	input  wire         opt_compat_in,
	input  wire         opt_truncate_in,
	input  wire         at_requested_channel_in,
	input  wire         printed_here_in,
	input  wire [5:0]   lines_to_tof_in,
	input  wire         opt_report_in,
	input  wire         opt_report_ch9_in,
	input  wire         channel9_in,
	input  wire         format_ready_in,
	input  wire         paper_motion_in,
	input  wire [W-1:0] forms_len_mem_in,
	input  wire [W-1:0] user_ctrl_in,
	input  wire [W-1:0] cfg_second_in,
	input  wire [3:0]   cfg_third_low_in,
	input  wire [3:0]   cfg_third_high_in,
	input  wire [3:0]   cfg_fourth_low_in,
	input  wire [3:0]   cfg_fourth_high_in,
	input  wire [W-1:0] interlock_status_in,
	input  wire [W-1:0] panel_switch_in,
	output reg          channel_search_out,
	output reg  [5:0]   skip_count_out,
	output reg          paper_move_req_out,
	output reg  [6:0]   source_sel_n_out,
	output reg  [W-1:0] cpu_input_bus_out,
	output reg          paper_moving_out,
	output reg          online_out,
	output reg          stepper_shift_n_out,
	output reg          load_column_n_out,
	output reg          clamp_off_n_out,
	output reg          clamp_on_n_out,
	output reg          clamp_voltage_en_out,
	output reg          high_rail_on_n_out,
	output reg          high_rail_off_n_out,
	output reg          high_rail_en_n_out,
	output reg          fault_clear_n_out,
	output reg          ribbon_sense_clear_n_out,
	output reg          format_addr_load_out,
	output reg          paper_motion_flag_clear_n_out,
	output reg          master_clear_set_n_out,
	output reg          display_load_n_out,
	output reg          buffer_clear_reset_n_out,
	output reg  [15:0]  group3_n_out
);
	// internal decode signals
	wire [7:0]   g0_q;
	wire [3:0]   code;
	wire [2:0]   latch_sel;
	wire         latch_value;
	wire [2:0]   src_code;
	wire         src_qualified;
	reg          ctrl_bit;
	reg          search_nxt;
	reg  [5:0]   count_nxt;
	reg          move_nxt;
	reg  [6:0]   sel_nxt;
	reg  [W-1:0] bus_nxt;
	reg  [15:0]  g3_nxt;
	reg          paper_nxt;

	// one-hot low decode of a four-bit code
	function [15:0] onehot_n;
		input [3:0] c;
		begin
			onehot_n = ~(16'h0001 << c);
		end
	endfunction

	// one-hot low decode of a source code
	function [6:0] sel_onehot_n;
		input [2:0] s;
		begin
			sel_onehot_n = ~(7'h01 << s);
		end
	endfunction

	// address bus fields
	assign code          = cpu_addr_line_in[`PIC_CODE_HI:`PIC_CODE_LO];
	assign latch_sel     = cpu_addr_line_in[`PIC_SEL_HI:`PIC_CODE_LO];
	assign latch_value   = cpu_addr_line_in[`PIC_VALUE_BIT];
	assign src_code      = cpu_addr_line_in[`PIC_SRC_HI:`PIC_SRC_LO];
	assign src_qualified = !source_strobe_n_in && cpu_addr_line_in[`PIC_QUAL_LO] && cpu_addr_line_in[`PIC_QUAL_HI];

	// group 0 addressable latch
	pic_latch8 u_group0
	(
		.clk_in      (clk_in),
		.rst_in      (rst_in),
		.clear_in    (group0_clear_in),
		.enable_n_in (group0_enable_n_in),
		.sel_in      (latch_sel),
		.value_in    (latch_value),
		.q_out       (g0_q)
	);

	// format unit command decode
	always @*
	begin
		ctrl_bit = opt_ctrl_bit_sel_in ? user_data_in[`PIC_DATA_CTRL_ON] : user_data_in[`PIC_DATA_CTRL_OFF];
		search_nxt = opt_polarity_in ? ctrl_bit : ~ctrl_bit;
		if (opt_long_count_in)
		begin
			if (opt_ctrl_bit_sel_in)
				count_nxt = {user_data_in[6:5], user_data_in[3:0]};
			else
				count_nxt = {user_data_in[7:6], user_data_in[3:0]};
		end
		else
			count_nxt = {2'h0, user_data_in[3:0]} & `PIC_SHORT_MAX;
		if (!search_nxt && opt_truncate_in && lines_to_tof_in != `PIC_COUNT_ZERO && count_nxt > lines_to_tof_in)
			count_nxt = lines_to_tof_in;
		if (search_nxt)
			move_nxt = !(opt_compat_in && at_requested_channel_in && !printed_here_in);
		else
			move_nxt = count_nxt != `PIC_COUNT_ZERO;
	end

	// input bus source decode
	always @*
	begin
		sel_nxt = `PIC_SEL_IDLE;
		bus_nxt = {W{1'b0}};
		if (src_qualified)
		begin
			if (src_code == `PIC_SRC_FORMS)
				bus_nxt = forms_len_mem_in;
			else if (src_code == `PIC_SRC_USER)
				bus_nxt = user_ctrl_in;
			else if (src_code == `PIC_SRC_CFG2)
				bus_nxt = cfg_second_in;
			else if (src_code == `PIC_SRC_CFG_LOW)
				bus_nxt = {cfg_fourth_low_in, cfg_third_low_in};
			else if (src_code == `PIC_SRC_CFG_HIGH)
				bus_nxt = {cfg_fourth_high_in, cfg_third_high_in};
			else if (src_code == `PIC_SRC_INTERLOCK)
				bus_nxt = interlock_status_in;
			else if (src_code == `PIC_SRC_PANEL)
				bus_nxt = panel_switch_in;
			if (src_code != `PIC_SRC_NONE)
				sel_nxt = sel_onehot_n(src_code);
		end
	end

	// group 3 decode and paper moving source
	always @*
	begin
		g3_nxt = group3_enable_n_in ? `PIC_G3_IDLE : onehot_n(code);
		if (opt_report_in)
			paper_nxt = opt_report_ch9_in ? channel9_in : format_ready_in;
		else
			paper_nxt = g0_q[`PIC_G0_PAPER_MOVE] & paper_motion_in;
	end

	// format unit outputs
	always @(posedge clk_in or posedge rst_in)
	begin
		if (rst_in)
		begin
			channel_search_out <= 1'b0;
			skip_count_out <= `PIC_COUNT_ZERO;
			paper_move_req_out <= 1'b0;
		end
		else
		begin
			channel_search_out <= search_nxt;
			skip_count_out <= search_nxt ? `PIC_COUNT_ZERO : count_nxt;
			paper_move_req_out <= move_nxt;
		end
	end

	// input bus outputs
	always @(posedge clk_in or posedge rst_in)
	begin
		if (rst_in)
		begin
			source_sel_n_out <= `PIC_SEL_IDLE;
			cpu_input_bus_out <= {W{1'b0}};
		end
		else
		begin
			source_sel_n_out <= sel_nxt;
			cpu_input_bus_out <= bus_nxt;
		end
	end

	// status lines to the user
	always @(posedge clk_in or posedge rst_in)
	begin
		if (rst_in)
		begin
			paper_moving_out <= 1'b0;
			online_out <= 1'b0;
		end
		else
		begin
			paper_moving_out <= paper_nxt;
			online_out <= g0_q[`PIC_G0_ONLINE];
		end
	end

	// group 3 pulse outputs
	always @(posedge clk_in or posedge rst_in)
	begin
		if (rst_in)
		begin
			group3_n_out <= `PIC_G3_IDLE;
			stepper_shift_n_out <= 1'b1;
			load_column_n_out <= 1'b1;
			clamp_off_n_out <= 1'b1;
			clamp_on_n_out <= 1'b1;
			high_rail_on_n_out <= 1'b1;
			high_rail_off_n_out <= 1'b1;
			fault_clear_n_out <= 1'b1;
			ribbon_sense_clear_n_out <= 1'b1;
			format_addr_load_out <= 1'b0;
			paper_motion_flag_clear_n_out <= 1'b1;
			master_clear_set_n_out <= 1'b1;
			display_load_n_out <= 1'b1;
			buffer_clear_reset_n_out <= 1'b1;
		end
		else
		begin
			group3_n_out <= g3_nxt;
			stepper_shift_n_out <= g3_nxt[`PIC_G3_STEPPER];
			load_column_n_out <= g3_nxt[`PIC_G3_LOAD_COL];
			clamp_off_n_out <= g3_nxt[`PIC_G3_CLAMP_OFF];
			clamp_on_n_out <= g3_nxt[`PIC_G3_CLAMP_ON];
			high_rail_on_n_out <= g3_nxt[`PIC_G3_RAIL_ON];
			high_rail_off_n_out <= g3_nxt[`PIC_G3_RAIL_OFF];
			fault_clear_n_out <= g3_nxt[`PIC_G3_FAULT_CLR];
			ribbon_sense_clear_n_out <= g3_nxt[`PIC_G3_RIBBON_CLR];
			format_addr_load_out <= ~g3_nxt[`PIC_G3_FMT_ADDR];
			paper_motion_flag_clear_n_out <= g3_nxt[`PIC_G3_PAPER_CLR];
			master_clear_set_n_out <= g3_nxt[`PIC_G3_MCLR_SET];
			display_load_n_out <= g3_nxt[`PIC_G3_DISPLAY];
			buffer_clear_reset_n_out <= g3_nxt[`PIC_G3_BUFCLR_RST];
		end
	end

	// clamp voltage enable latch
	always @(posedge clk_in or posedge rst_in)
	begin
		if (rst_in)
			clamp_voltage_en_out <= 1'b0;
		else if (!g3_nxt[`PIC_G3_CLAMP_OFF])
			clamp_voltage_en_out <= 1'b0;
		else if (!g3_nxt[`PIC_G3_CLAMP_ON])
			clamp_voltage_en_out <= 1'b1;
	end

	// high rail enable latch
	always @(posedge clk_in or posedge rst_in)
	begin
		if (rst_in)
			high_rail_en_n_out <= 1'b1;
		else if (!g3_nxt[`PIC_G3_RAIL_ON])
			high_rail_en_n_out <= 1'b0;
		else if (!g3_nxt[`PIC_G3_RAIL_OFF])
			high_rail_en_n_out <= 1'b1;
	end
endmodule // pic_control_decode

// File: pic_cpu_model.sv
// processor card model driving group enables and address lines
`timescale 1ns/1ns
module pic_cpu_model
(
	input  wire        clk_in,
	output reg         group0_enable_n_out,
	output reg         group3_enable_n_out,
	output reg         source_strobe_n_out,
	output reg  [15:0] cpu_addr_line_out
);
	initial {group0_enable_n_out, group3_enable_n_out, source_strobe_n_out, cpu_addr_line_out} = 19'h70000;
	// one access held over one rising edge, then released with a changed address
	task access(input [2:0] en_n, input [15:0] addr);
	begin
		@(negedge clk_in) {group0_enable_n_out, group3_enable_n_out, source_strobe_n_out, cpu_addr_line_out} = {en_n, addr};
		@(negedge clk_in) {group0_enable_n_out, group3_enable_n_out, source_strobe_n_out, cpu_addr_line_out} = {3'h7, ~addr};
	end
	endtask
endmodule // pic_cpu_model

// File: pic_decode_checker.sv
// assertions on the control decode ports
`timescale 1ns/1ns
module pic_decode_checker
(
	input wire        clk_in,
	input wire        rst_in,
	input wire        group0_enable_n_in,
	input wire        group0_clear_in,
	input wire        group3_enable_n_in,
	input wire        source_strobe_n_in,
	input wire [15:0] cpu_addr_line_in,
	input wire        online_out,
	input wire [6:0]  source_sel_n_out,
	input wire        clamp_voltage_en_out,
	input wire        high_rail_en_n_out,
	input wire [15:0] group3_n_out
);
	default clocking @(posedge clk_in);
	endclocking
	default disable iff (rst_in);
	wire [3:0] c3 = cpu_addr_line_in[13:10];
	wire [2:0] cs = cpu_addr_line_in[11:9];
	wire       g3 = !group3_enable_n_in;
	wire       sq = !source_strobe_n_in && cpu_addr_line_in[13:12] == 2'h3;
	property p_g3_hot; g3 |=> group3_n_out == ~(16'h1 << $past(c3)); endproperty
	a_g3_hot: assert property (p_g3_hot) else $error("g3 decode");
	property p_g3_idle; !g3 |=> group3_n_out == 16'hFFFF; endproperty
	a_g3_idle: assert property (p_g3_idle) else $error("g3 idle");
	property p_clamp_on; g3 && c3 == 4'h4 |=> clamp_voltage_en_out; endproperty
	a_clamp_on: assert property (p_clamp_on) else $error("clamp on");
	property p_clamp_off; g3 && c3 == 4'h3 |=> !clamp_voltage_en_out; endproperty
	a_clamp_off: assert property (p_clamp_off) else $error("clamp off");
	property p_rail_on; g3 && c3 == 4'h5 |=> !high_rail_en_n_out [*2]; endproperty
	a_rail_on: assert property (p_rail_on) else $error("rail on");
	property p_src_sel; sq && cs != 3'h7 |=> source_sel_n_out == ~(7'h1 << $past(cs)); endproperty
	a_src_sel: assert property (p_src_sel) else $error("source select");
	property p_src_idle; !sq |=> source_sel_n_out == 7'h7F; endproperty
	a_src_idle: assert property (p_src_idle) else $error("source idle");
	property p_online; !group0_enable_n_in && cpu_addr_line_in[12:10] == 3'h1 && !group0_clear_in ##1 !group0_clear_in
		|=> online_out == $past(cpu_addr_line_in[13], 2); endproperty
	a_online: assert property (p_online) else $error("online");
endmodule // pic_decode_checker
bind pic_control_decode pic_decode_checker chk_u (.*);

// File: pic_control_decode_bench.sv
// self-checking bench for the control decode
`timescale 1ns/1ns
module pic_control_decode_bench;
	logic        clk_in = 1'h0, rst_in = 1'h1, group0_clear_in = 1'h0, channel9_in = 1'h0;
	logic        opt_ctrl_bit_sel_in = 1'h0, opt_polarity_in = 1'h0, opt_long_count_in = 1'h0, opt_compat_in = 1'h0;
	logic        opt_truncate_in = 1'h0, opt_report_in = 1'h0, opt_report_ch9_in = 1'h0;
	logic [7:0]  user_data_in = 8'h00, k = 8'h00;
	logic [7:0]  xt [8] = '{8'h11, 8'h22, 8'h33, 8'h54, 8'h76, 8'h88, 8'h99, 8'h00};
	wire         at_requested_channel_in = 1'h1, printed_here_in = 1'h0, format_ready_in = 1'h0, paper_motion_in = 1'h1;
	wire  [5:0]  lines_to_tof_in = 6'h03;
	wire  [7:0]  forms_len_mem_in = k ^ xt[0], user_ctrl_in = k ^ xt[1], cfg_second_in = k ^ xt[2];
	wire  [7:0]  interlock_status_in = k ^ xt[5], panel_switch_in = k ^ xt[6];
	wire  [3:0]  cfg_third_low_in = k[3:0] ^ 4'h4, cfg_fourth_low_in = k[7:4] ^ 4'h5;
	wire  [3:0]  cfg_third_high_in = k[3:0] ^ 4'h6, cfg_fourth_high_in = k[7:4] ^ 4'h7;
	wire         group0_enable_n_in, group3_enable_n_in, source_strobe_n_in;
	wire  [15:0] cpu_addr_line_in, group3_n_out;
	wire  [7:0]  cpu_input_bus_out;
	wire  [6:0]  source_sel_n_out;
	wire  [5:0]  skip_count_out;
	wire         channel_search_out, paper_move_req_out, paper_moving_out, online_out, stepper_shift_n_out;
	wire         load_column_n_out, clamp_off_n_out, clamp_on_n_out, clamp_voltage_en_out, high_rail_on_n_out;
	wire         high_rail_off_n_out, high_rail_en_n_out, fault_clear_n_out, ribbon_sense_clear_n_out;
	wire         format_addr_load_out, paper_motion_flag_clear_n_out, master_clear_set_n_out, display_load_n_out;
	wire         buffer_clear_reset_n_out;
	wire  [9:0]  pulses_n = {stepper_shift_n_out, load_column_n_out, clamp_off_n_out, clamp_on_n_out,
		high_rail_on_n_out, high_rail_off_n_out, ribbon_sense_clear_n_out, paper_motion_flag_clear_n_out,
		master_clear_set_n_out, display_load_n_out};
	int          errors = 0, comparisons = 0, cycles = 0;
	pic_cpu_model cpu_u
	(
		.clk_in              (clk_in),
		.group0_enable_n_out (group0_enable_n_in),
		.group3_enable_n_out (group3_enable_n_in),
		.source_strobe_n_out (source_strobe_n_in),
		.cpu_addr_line_out   (cpu_addr_line_in)
	);
	pic_control_decode dut_u (.*);
	always #2 clk_in = ~clk_in;
	always @(posedge clk_in)
	begin
		cycles++;
		if (cycles == 1000)
		begin
			errors++;
			print_verdict;
		end
	end
	task print_verdict;
	begin
		$display("comparisons %0d errors %0d", comparisons, errors);
		if (errors == 0 && comparisons > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	end
	endtask
	task chk(input string nm, input [15:0] e, input [15:0] g);
	begin
		comparisons++;
		if (g !== e)
		begin
			errors++;
			$display("CHECK FAILED %s expected %h seen %h", nm, e, g);
		end
	end
	endtask
	task g0(input [2:0] a, input v);
	begin
		cpu_u.access(3'h3, {2'h0, v, a, 10'h000});
		@(negedge clk_in);
	end
	endtask
	// option bits are select, polarity, long count, compatibility, truncate
	task fmt(input [4:0] o, input [7:0] d, input s, input [5:0] n);
	begin
		@(negedge clk_in) {opt_ctrl_bit_sel_in, opt_polarity_in, opt_long_count_in, opt_compat_in, opt_truncate_in} = o;
		user_data_in = d;
		@(negedge clk_in) chk("search", s, channel_search_out);
		chk("count", n, skip_count_out);
		chk("move", !(o[1] && s), paper_move_req_out);
	end
	endtask
	initial
	begin
		repeat (4) @(negedge clk_in);
		rst_in = 1'h0;
		fmt(5'h18, 8'h80, 1'h1, 6'h00);
		fmt(5'h08, 8'h20, 1'h1, 6'h00);
		fmt(5'h00, 8'h25, 1'h0, 6'h05);
		fmt(5'h1C, 8'h6F, 1'h0, 6'h3F);
		fmt(5'h04, 8'hAF, 1'h0, 6'h2F);
		fmt(5'h18, 8'h6F, 1'h0, 6'h0F);
		fmt(5'h19, 8'h0F, 1'h0, 6'h03);
		fmt(5'h1A, 8'h80, 1'h1, 6'h00);
		g0(3'h0, 1'h1);
		g0(3'h1, 1'h1);
		g0(3'h2, 1'h0);
		chk("online", 1'h1, online_out);
		chk("pmove", 1'h1, paper_moving_out);
		g0(3'h1, 1'h0);
		chk("online", 1'h0, online_out);
		g0(3'h0, 1'h0);
		chk("pmove", 1'h0, paper_moving_out);
		g0(3'h1, 1'h1);
		group0_clear_in = 1'h1;
		@(negedge clk_in) group0_clear_in = 1'h0;
		@(negedge clk_in) chk("clear", 1'h0, online_out);
		{opt_report_in, opt_report_ch9_in, channel9_in} = 3'h7;
		repeat (2) @(negedge clk_in);
		chk("report", 1'h1, paper_moving_out);
		for (int c = 0; c < 16; c++)
		begin
			cpu_u.access(3'h5, {2'h0, 4'(c), 10'h000});
			chk("g3", ~(16'h1 << c), group3_n_out);
			chk("clamp", c > 3, clamp_voltage_en_out);
			chk("rail", c != 5, high_rail_en_n_out);
			chk("fault", c != 7, fault_clear_n_out);
			chk("pulses", {c != 1, c != 2, c != 3, c != 4, c != 5, c != 6, c != 8, c != 10, c != 11, c != 13}, pulses_n);
			chk("faddr", c == 9, format_addr_load_out);
			chk("bufclr", c != 15, buffer_clear_reset_n_out);
		end
		@(negedge clk_in) chk("g3", 16'hFFFF, group3_n_out);
		for (int p = 0; p < 2; p++)
		begin
			k = p ? 8'hA5 : 8'h00;
			for (int c = 0; c < 8; c++)
			begin
				cpu_u.access(3'h6, {4'h3, 3'(c), 9'h000});
				chk("sel", c == 7 ? 7'h7F : 7'(~(7'h1 << c)), source_sel_n_out);
				chk("bus", c == 7 ? 8'h00 : k ^ xt[c], cpu_input_bus_out);
			end
		end
		print_verdict;
	end
endmodule // pic_control_decode_bench
